// [rtl/sbt_boot_dev.sv]
module sbt_boot_dev #(
    parameter int BIT_CYC = sbt_pkg::BIT_CYC_DEF,
    parameter int SUM_CYC = sbt_pkg::SUM_CYC,
    parameter int WRITE_CYC = sbt_pkg::WRITE_CYC,
    parameter int CHIP_ERASE_CYC = sbt_pkg::CHIP_ERASE_CYC,
    parameter int SECT_ERASE_CYC = sbt_pkg::SECT_ERASE_CYC,
    parameter int PROG_CYC = sbt_pkg::PROG_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    sbt_link_if.dev link,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    input wire logic [7:0] tx_data,
    input wire sbt_pkg::sbt_op_type tx_op,
    input wire logic [1:0] tx_sec_bits,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic tx_busy,
    output logic link_active
);
    localparam logic [15:0] BIT_W = 16'(BIT_CYC);
    localparam logic [15:0] HALF_W = 16'(BIT_CYC / 2);

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } sbt_rx_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_SHIFT = 2'b11
    } sbt_tx_type;

    // ======================================================
    // Pin synchronisers
    logic rx_m_r;
    logic rx_s_r;
    logic hold_m_r;
    logic hold_s_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            hold_m_r <= 1'b0;
            hold_s_r <= 1'b0;
        end else if (ce) begin
            rx_m_r <= link.host_tx;
            rx_s_r <= rx_m_r;
            hold_m_r <= link.boot_hold_n;
            hold_s_r <= hold_m_r;
        end
    end

    assign link_active = hold_s_r;

    // ======================================================
    // Receiver
    sbt_rx_type rx_st_r;
    logic [15:0] rx_cnt_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_done_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_done_r <= 1'b0;
        end else if (ce) begin
            rx_done_r <= 1'b0;
            case (rx_st_r)
                RX_IDLE: begin
                    // Pins held low keep the receiver deaf
                    if (hold_s_r && !rx_s_r) begin
                        rx_st_r <= RX_START;
                        rx_cnt_r <= HALF_W - 16'h0001;
                    end
                end
                RX_START: begin
                    if (rx_cnt_r == 16'h0000) begin
                        // A glitch shorter than half a bit is dropped
                        rx_st_r <= rx_s_r ? RX_IDLE : RX_DATA;
                        rx_cnt_r <= BIT_W - 16'h0001;
                        rx_bit_r <= 3'h0;
                    end else begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_r == 16'h0000) begin
                        rx_sh_r <= {rx_s_r, rx_sh_r[7:1]};
                        rx_cnt_r <= BIT_W - 16'h0001;
                        if (rx_bit_r == 3'h7) begin
                            rx_st_r <= RX_STOP;
                        end else begin
                            rx_bit_r <= rx_bit_r + 3'h1;
                        end
                    end else begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end
                end
                default: begin
                    if (rx_cnt_r == 16'h0000) begin
                        rx_st_r <= RX_IDLE;
                        rx_done_r <= rx_s_r;
                    end else begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // Time since the last received byte, in gear clocks
    logic [31:0] el_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            el_r <= 32'h0000_0000;
        end else if (ce) begin
            if (rx_done_r) begin
                el_r <= 32'h0000_0000;
            end else if (el_r != 32'hFFFF_FFFF) begin
                el_r <= el_r + 32'h0000_0001;
            end
        end
    end

    // ======================================================
    // Two-entry receive buffer
    logic [7:0] b0_r;
    logic [7:0] b1_r;
    logic [1:0] bcnt_r;
    logic [1:0] bcnt_nxt;
    logic b_push;
    logic b_pop;
    logic b_ready_r;

    assign b_push = rx_done_r && b_ready_r;
    assign b_pop = rx_valid && rx_ready;
    assign bcnt_nxt = bcnt_r + {1'b0, b_push} - {1'b0, b_pop};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            b0_r <= 8'h00;
            b1_r <= 8'h00;
            bcnt_r <= 2'h0;
            b_ready_r <= 1'b1;
            rx_valid <= 1'b0;
        end else if (ce) begin
            bcnt_r <= bcnt_nxt;
            b_ready_r <= bcnt_nxt != 2'h2;
            rx_valid <= bcnt_nxt != 2'h0;
            if (b_pop) begin
                b0_r <= (b_push && bcnt_r == 2'h1) ? rx_sh_r : b1_r;
                if (b_push && bcnt_r == 2'h2) begin
                    b1_r <= rx_sh_r;
                end
            end else if (b_push) begin
                if (bcnt_r == 2'h0) begin
                    b0_r <= rx_sh_r;
                end else begin
                    b1_r <= rx_sh_r;
                end
            end
        end
    end

    assign rx_data = b0_r;

    // A byte arriving on a full buffer cannot be held back on the wire
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_overrun <= 1'b0;
        end else if (ce) begin
            if (rx_done_r && !b_ready_r) begin
                rx_overrun <= 1'b1;
            end else if (b_pop) begin
                rx_overrun <= 1'b0;
            end
        end
    end

    // ======================================================
    // Answer delay per operation
    logic [31:0] dly;

    always_comb begin
        case (tx_op)
            sbt_pkg::OP_SYNC: dly = 32'(sbt_pkg::SYNC_ECHO_CYC);
            sbt_pkg::OP_ACK: dly = 32'(sbt_pkg::ACK_ECHO_CYC);
            sbt_pkg::OP_CMD: dly = 32'(sbt_pkg::CMD_ECHO_CYC);
            sbt_pkg::OP_SUM: dly = 32'(SUM_CYC);
            sbt_pkg::OP_WRITE: dly = 32'(WRITE_CYC);
            sbt_pkg::OP_CHIP_ERASE: dly = 32'(CHIP_ERASE_CYC);
            sbt_pkg::OP_SECT_ERASE: dly = 32'(SECT_ERASE_CYC);
            sbt_pkg::OP_HEX: dly = 32'(sbt_pkg::HEX_MIN);
            sbt_pkg::OP_SECURITY: begin
                // Each programmed bit costs processing plus one program pulse
                dly = 32'(sbt_pkg::SEC_BASE)
                    + 32'(tx_sec_bits) * 32'(sbt_pkg::SEC_BIT + PROG_CYC);
            end
            sbt_pkg::OP_CLKSET: dly = 32'(sbt_pkg::CLKSET_ECHO_CYC);
            sbt_pkg::OP_CLK80: dly = 32'(sbt_pkg::CLK80_ECHO_CYC);
            default: dly = 32'h0000_0000;
        endcase
    end

    // ======================================================
    // Transmitter
    sbt_tx_type tx_st_r;
    logic [9:0] tx_sh_r;
    logic [15:0] tx_cnt_r;
    logic [3:0] tx_n_r;
    logic [31:0] dly_r;
    logic tx_line_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_st_r <= TX_IDLE;
            tx_sh_r <= 10'h3FF;
            tx_cnt_r <= 16'h0000;
            tx_n_r <= 4'h0;
            dly_r <= 32'h0000_0000;
            tx_line_r <= 1'b1;
            tx_ready <= 1'b0;
            tx_busy <= 1'b0;
        end else if (ce) begin
            case (tx_st_r)
                TX_IDLE: begin
                    if (tx_valid && tx_ready) begin
                        dly_r <= dly;
                        tx_sh_r <= {1'b1, tx_data, 1'b0};
                        tx_ready <= 1'b0;
                        tx_busy <= 1'b1;
                        tx_st_r <= TX_WAIT;
                    end else begin
                        tx_ready <= hold_s_r;
                        tx_busy <= 1'b0;
                    end
                end
                TX_WAIT: begin
                    // Late answers go out at once; early ones wait out the delay
                    if (el_r >= dly_r) begin
                        tx_st_r <= TX_SHIFT;
                        tx_cnt_r <= BIT_W - 16'h0001;
                        tx_n_r <= 4'h0;
                        tx_line_r <= tx_sh_r[0];
                    end
                end
                default: begin
                    if (tx_cnt_r != 16'h0000) begin
                        tx_cnt_r <= tx_cnt_r - 16'h0001;
                    end else if (tx_n_r == 4'h9) begin
                        tx_st_r <= TX_IDLE;
                        tx_line_r <= 1'b1;
                    end else begin
                        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                        tx_line_r <= tx_sh_r[1];
                        tx_n_r <= tx_n_r + 4'h1;
                        tx_cnt_r <= BIT_W - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign link.dev_tx = tx_line_r;
endmodule

// [rtl/sbt_boot_host.sv]
module sbt_boot_host #(
    parameter int BIT_CYC = sbt_pkg::BIT_CYC_DEF,
    parameter int MARGIN_CYC = sbt_pkg::MARGIN_CYC_DEF,
    parameter int RST_HOLD_CYC = sbt_pkg::RST_HOLD_CYC,
    parameter int RX_SETUP_CYC = sbt_pkg::RX_SETUP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    sbt_link_if.host link,
    input wire logic [7:0] in_data,
    input wire logic in_reply,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    output logic link_up
);
    localparam logic [15:0] BIT_W = 16'(BIT_CYC);
    localparam logic [15:0] HALF_W = 16'(BIT_CYC / 2);

    typedef enum logic [2:0] {
        H_HOLD = 3'b000,
        H_SETUP = 3'b001,
        H_IDLE = 3'b011,
        H_SEND = 3'b010,
        H_REPLY = 3'b110,
        H_GAP = 3'b111
    } sbt_host_type;

    // ======================================================
    // Receiver of device answers
    logic rx_m_r;
    logic rx_s_r;
    logic [1:0] rx_st_r;
    logic [15:0] rx_cnt_r;
    logic [3:0] rx_n_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_m_r <= 1'b1;
            rx_s_r <= 1'b1;
            rx_st_r <= 2'b00;
            rx_cnt_r <= 16'h0000;
            rx_n_r <= 4'h0;
            out_data <= 8'h00;
            out_valid <= 1'b0;
        end else if (ce) begin
            rx_m_r <= link.dev_tx;
            rx_s_r <= rx_m_r;
            out_valid <= 1'b0;
            if (rx_st_r == 2'b00) begin
                if (!rx_s_r) begin
                    rx_st_r <= 2'b01;
                    rx_cnt_r <= HALF_W - 16'h0001;
                    rx_n_r <= 4'h0;
                end
            end else if (rx_cnt_r != 16'h0000) begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end else begin
                rx_cnt_r <= BIT_W - 16'h0001;
                rx_n_r <= rx_n_r + 4'h1;
                if (rx_n_r == 4'h0) begin
                    rx_st_r <= rx_s_r ? 2'b00 : 2'b01;
                end else if (rx_n_r == 4'h9) begin
                    rx_st_r <= 2'b00;
                    out_valid <= rx_s_r;
                end else begin
                    out_data <= {rx_s_r, out_data[7:1]};
                end
            end
        end
    end

    // ======================================================
    // Two-entry send buffer, drained only when the link allows
    sbt_host_type st_r;
    logic [8:0] b0_r;
    logic [8:0] b1_r;
    logic [1:0] bcnt_r;
    logic [1:0] bcnt_nxt;
    logic b_push;
    logic b_pop;
    logic b_valid_r;

    assign b_push = in_valid && in_ready;
    assign b_pop = b_valid_r && st_r == H_IDLE;
    assign bcnt_nxt = bcnt_r + {1'b0, b_push} - {1'b0, b_pop};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            b0_r <= 9'h000;
            b1_r <= 9'h000;
            bcnt_r <= 2'h0;
            in_ready <= 1'b1;
            b_valid_r <= 1'b0;
        end else if (ce) begin
            bcnt_r <= bcnt_nxt;
            in_ready <= bcnt_nxt != 2'h2;
            b_valid_r <= bcnt_nxt != 2'h0;
            if (b_pop) begin
                b0_r <= (b_push && bcnt_r == 2'h1) ? {in_reply, in_data} : b1_r;
                if (b_push && bcnt_r == 2'h2) begin
                    b1_r <= {in_reply, in_data};
                end
            end else if (b_push) begin
                if (bcnt_r == 2'h0) begin
                    b0_r <= {in_reply, in_data};
                end else begin
                    b1_r <= {in_reply, in_data};
                end
            end
        end
    end

    // ======================================================
    // Turnaround after each device byte; 751 covers the shorter gaps
    logic [31:0] gap;

    always_comb begin
        if (out_data == sbt_pkg::SYNC_BYTE) begin
            gap = 32'(sbt_pkg::GAP_SYNC);
        end else if (out_data == sbt_pkg::ACK_BYTE) begin
            gap = 32'(sbt_pkg::GAP_ACK);
        end else if (out_data == sbt_pkg::CLK80_BYTE) begin
            gap = 32'(sbt_pkg::GAP_CLK80);
        end else begin
            gap = 32'(sbt_pkg::GAP_NEXT);
        end
        gap = gap + 32'(BIT_CYC) + 32'(MARGIN_CYC);
    end

    // ======================================================
    // Sequencer
    logic [31:0] cnt_r;
    logic [31:0] gap_r;
    logic [9:0] sh_r;
    logic [3:0] n_r;
    logic reply_r;
    logic line_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= H_HOLD;
            cnt_r <= 32'h0000_0000;
            gap_r <= 32'h0000_0000;
            sh_r <= 10'h3FF;
            n_r <= 4'h0;
            reply_r <= 1'b0;
            line_r <= 1'b1;
            link_up <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_r + 32'h0000_0001;
            case (st_r)
                H_HOLD: begin
                    if (cnt_r >= 32'(RST_HOLD_CYC - 1)) begin
                        st_r <= H_SETUP;
                        cnt_r <= 32'h0000_0000;
                    end
                end
                H_SETUP: begin
                    if (cnt_r >= 32'(RX_SETUP_CYC - 1)) begin
                        st_r <= H_IDLE;
                        link_up <= 1'b1;
                    end
                end
                H_IDLE: begin
                    if (b_pop) begin
                        sh_r <= {1'b1, b0_r[7:0], 1'b0};
                        reply_r <= b0_r[8];
                        line_r <= 1'b0;
                        n_r <= 4'h0;
                        cnt_r <= 32'h0000_0000;
                        st_r <= H_SEND;
                    end
                end
                H_SEND: begin
                    if (cnt_r >= 32'(BIT_CYC - 1)) begin
                        cnt_r <= 32'h0000_0000;
                        n_r <= n_r + 4'h1;
                        sh_r <= {1'b1, sh_r[9:1]};
                        line_r <= sh_r[1];
                        if (n_r == 4'h9) begin
                            line_r <= 1'b1;
                            gap_r <= 32'(BIT_CYC) + 32'(MARGIN_CYC);
                            st_r <= reply_r ? H_REPLY : H_GAP;
                        end
                    end
                end
                H_REPLY: begin
                    if (out_valid) begin
                        gap_r <= gap;
                        cnt_r <= 32'h0000_0000;
                        st_r <= H_GAP;
                    end
                end
                default: begin
                    // A further answer byte restarts the turnaround
                    if (out_valid) begin
                        gap_r <= gap;
                        cnt_r <= 32'h0000_0000;
                    end else if (cnt_r >= gap_r) begin
                        st_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.boot_hold_n <= 1'b0;
        end else if (ce) begin
            link.boot_hold_n <= st_r != H_HOLD;
        end
    end

    assign link.host_tx = line_r;
endmodule

// [rtl/sbt_link_if.sv]
interface sbt_link_if;
    logic host_tx;
    logic dev_tx;
    logic boot_hold_n;

    modport dev (
        input host_tx,
        input boot_hold_n,
        output dev_tx
    );

    modport host (
        output host_tx,
        output boot_hold_n,
        input dev_tx
    );
endinterface

// [rtl/sbt_pkg.sv]
// Functional notes
// - Host holds mode/reset low 10 ms
// - Host waits 20 ms before first byte
// - After 0x86 echo, wait one bit
// - After 0x79 echo, wait 49 cycles+bit
// - After command echo, wait one bit
// - After command completes, wait 751 cycles+bit
// - After clock data echo, wait 181 cycles+bit
// - After 0x80 sent, wait 35 cycles+bit
// - Command echo within 105 to 241 cycles
// - Sum output checksum takes 5605040 cycles
// - Write checksum takes 5456240 cycles
// - Erase: chip 5338530+500ms, sector 5338365+100ms
// - Hex record answer 182 to 32000+1.25ms
// - Security: 857 plus (193+1.25ms) per bit
// - Host adds safety margin to waits
// - Bit time is current baud period
package sbt_pkg;
    // ======================================================
    // Clock and link
    localparam int CLK_HZ = 10_000_000;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    localparam int BIT_CYC_DEF = 1042;
    localparam int MARGIN_CYC_DEF = 16;

    // ======================================================
    // Host-side setup times
    localparam int RST_HOLD_MS = 10;
    localparam int RX_SETUP_MS = 20;
    localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000 * US_CYC;
    localparam int RX_SETUP_CYC = RX_SETUP_MS * 1000 * US_CYC;

    // ======================================================
    // Host turnaround gaps in gear clocks, bit time added on top
    localparam int GAP_SYNC = 0;
    localparam int GAP_ACK = 49;
    localparam int GAP_NEXT = 751;
    localparam int GAP_CLKSET = 181;
    localparam int GAP_CLK80 = 35;

    // ======================================================
    // Device processing times in gear clocks
    localparam int SYNC_ECHO_CYC = 583;
    localparam int ACK_ECHO_CYC = 526;
    localparam int CMD_ECHO_MIN = 105;
    localparam int CMD_ECHO_MAX = 241;
    localparam int CMD_ECHO_CYC = 150;
    localparam int SUM_CYC = 5605040;
    localparam int WRITE_CYC = 5456240;
    localparam int CHIP_ERASE_MS = 500;
    localparam int SECT_ERASE_MS = 100;
    localparam int CHIP_ERASE_CYC = 5338530 + CHIP_ERASE_MS * 1000 * US_CYC;
    localparam int SECT_ERASE_CYC = 5338365 + SECT_ERASE_MS * 1000 * US_CYC;
    localparam int PROG_US = 1250;
    localparam int PROG_CYC = PROG_US * US_CYC;
    localparam int HEX_MIN = 182;
    localparam int HEX_MAX = 32000 + PROG_CYC;
    localparam int SEC_BASE = 857;
    localparam int SEC_BIT = 193;
    localparam int CLKSET_ECHO_CYC = 93;
    localparam int CLK80_ECHO_CYC = 570;

    // ======================================================
    // Protocol bytes
    localparam logic [7:0] SYNC_BYTE = 8'h86;
    localparam logic [7:0] ACK_BYTE = 8'h79;
    localparam logic [7:0] CLK80_BYTE = 8'h80;

    typedef enum logic [3:0] {
        OP_SYNC = 4'h0,
        OP_ACK = 4'h1,
        OP_CMD = 4'h2,
        OP_SUM = 4'h3,
        OP_WRITE = 4'h4,
        OP_CHIP_ERASE = 4'h5,
        OP_SECT_ERASE = 4'h6,
        OP_HEX = 4'h7,
        OP_SECURITY = 4'h8,
        OP_CLKSET = 4'h9,
        OP_CLK80 = 4'hA,
        OP_NOW = 4'hB
    } sbt_op_type;
endpackage

// [tb/sbt_link_assertions.sv]
module sbt_link_assertions #(
    parameter int BIT_CYC = 16,
    parameter int RST_HOLD_CYC = 50,
    parameter int RX_SETUP_CYC = 50
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic host_tx,
    input wire logic dev_tx,
    input wire logic boot_hold_n
);
    localparam int FRAME = 10 * BIT_CYC;
    localparam int STOP_MID = 9 * BIT_CYC + BIT_CYC / 2;
    int d_cnt;
    int h_cnt;
    int gap;
    int hold;
    int up;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ==========================================
    // Frame trackers; a start is only taken from an idle line
    always_ff @(posedge core_clk) begin
        if (rst || d_cnt == FRAME - 1)
            d_cnt <= 0;
        else if (d_cnt != 0 || !dev_tx)
            d_cnt <= d_cnt + 1;
    end
    always_ff @(posedge core_clk) begin
        if (rst || h_cnt == FRAME - 1)
            h_cnt <= 0;
        else if (h_cnt != 0 || !host_tx)
            h_cnt <= h_cnt + 1;
    end
    // Saturates so a long idle cannot wrap
    always_ff @(posedge core_clk) begin
        if (rst || !dev_tx)
            gap <= 0;
        else if (gap < 100000)
            gap <= gap + 1;
    end
    always_ff @(posedge core_clk) begin
        if (rst)
            hold <= 0;
        else if (!boot_hold_n)
            hold <= hold + 1;
    end
    always_ff @(posedge core_clk) begin
        if (rst || !boot_hold_n)
            up <= 0;
        else
            up <= up + 1;
    end
    // ==========================================
    // Checks
    sequence dev_start_s;
        $fell(dev_tx) && d_cnt == 0;
    endsequence
    sequence host_start_s;
        $fell(host_tx) && h_cnt == 0;
    endsequence
    chk_dev_start_bit: assert property (dev_start_s |-> !dev_tx [*8])
        else $error("device start bit too short");
    chk_dev_stop_bit: assert property (d_cnt == STOP_MID |-> dev_tx)
        else $error("device stop bit missing");
    chk_host_start_bit: assert property (h_cnt == BIT_CYC / 2 |-> !host_tx)
        else $error("host start bit too short");
    chk_host_stop_bit: assert property (h_cnt == STOP_MID |-> host_tx)
        else $error("host stop bit missing");
    chk_host_turn_gap: assert property (host_start_s |-> gap > BIT_CYC)
        else $error("host sent too soon after device byte");
    chk_hold_low_time: assert property ($rose(boot_hold_n) |-> hold >= RST_HOLD_CYC - 1)
        else $error("hold released too early");
    chk_rx_setup_time: assert property (host_start_s |-> up >= RX_SETUP_CYC - 1)
        else $error("first byte too early after release");
    chk_idle_while_held: assert property (!boot_hold_n |-> host_tx && dev_tx)
        else $error("line active while held");
endmodule

// [tb/serial_boot_uart_timing_bench.sv]
module serial_boot_uart_timing_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT = 16;
    localparam int HOLD = 50;
    localparam int SETUP = 50;
    localparam int PROG = 40;
    // Answer delay per op code; long counts shortened to keep the run short
    localparam int DLY [12] = '{583, 526, 150, 300, 310, 320, 330, 182,
        857 + 3 * (193 + PROG), 93, 570, 0};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic in_valid = 1'b0;
    logic in_reply = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] in_data = 8'h00;
    logic [1:0] tx_sec_bits = 2'h3;
    sbt_pkg::sbt_op_type tx_op = sbt_pkg::OP_NOW;
    logic [7:0] rx_data, out_data;
    logic rx_valid, rx_overrun, tx_ready, link_active, in_ready, out_valid, link_up;
    int cyc = 0;
    int errors = 0;
    int samples_checked = 0;
    sbt_link_if link ();
    sbt_boot_dev #(.BIT_CYC(BIT), .SUM_CYC(300), .WRITE_CYC(310), .CHIP_ERASE_CYC(320),
        .SECT_ERASE_CYC(330), .PROG_CYC(PROG)) i_sbt_boot_dev (.core_clk(core_clk),
        .rst(rst), .ce(ce), .link(link), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .tx_data(tx_data), .tx_op(tx_op),
        .tx_sec_bits(tx_sec_bits), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(),
        .link_active(link_active));
    sbt_boot_host #(.BIT_CYC(BIT), .RST_HOLD_CYC(HOLD), .RX_SETUP_CYC(SETUP)) i_sbt_boot_host (
        .core_clk(core_clk), .rst(rst), .ce(ce), .link(link), .in_data(in_data),
        .in_reply(in_reply), .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
        .out_valid(out_valid), .link_up(link_up));
    sbt_link_assertions #(.BIT_CYC(BIT), .RST_HOLD_CYC(HOLD), .RX_SETUP_CYC(SETUP))
        i_sbt_link_assertions (.core_clk(core_clk), .rst(rst), .host_tx(link.host_tx),
        .dev_tx(link.dev_tx), .boot_hold_n(link.boot_hold_n));
    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic host_send(input logic [7:0] b, input logic reply);
        in_data <= b;
        in_reply <= reply;
        in_valid <= 1'b1;
        do @(posedge core_clk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic dev_answer(input logic [7:0] b, input int op);
        tx_data <= b;
        tx_op <= sbt_pkg::sbt_op_type'(op[3:0]);
        tx_valid <= 1'b1;
        do @(posedge core_clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic pop();
        rx_ready <= 1'b1;
        @(posedge core_clk);
        rx_ready <= 1'b0;
        @(posedge core_clk);
    endtask
    // ==========================================
    // Scenarios
    task automatic test_setup();
        for (int n = 0; n < 400 && link_active !== 1'b1; n++) @(posedge core_clk);
        check("hold time", 1, cyc >= 16 + HOLD);
        for (int n = 0; n < 400 && link_up !== 1'b1; n++) @(posedge core_clk);
        check("setup time", 1, cyc >= 16 + HOLD + SETUP);
        $display("test_setup done");
    endtask
    task automatic test_ops();
        logic [7:0] b;
        int t0, t1, g;
        for (int i = 0; i < 12; i++) begin
            b = (i == 0) ? 8'h86 : (i == 1) ? 8'h79 : (i == 10) ? 8'h80 : 8'h30 + 8'(i);
            host_send(b, 1'b1);
            for (int n = 0; n < 2000 && link.host_tx !== 1'b0; n++) @(posedge core_clk);
            if (i > 0)
                check("host gap", 1, cyc - t1 >= g + BIT);
            for (int n = 0; n < 3000 && rx_valid !== 1'b1; n++) @(posedge core_clk);
            check("rx_data", b, rx_data);
            t0 = cyc;
            pop();
            dev_answer(b, i);
            for (int n = 0; n < 3000 && link.dev_tx !== 1'b0; n++) @(posedge core_clk);
            check("answer delay", 1, cyc - t0 + 4 >= DLY[i] && cyc - t0 <= DLY[i] + 8);
            for (int n = 0; n < 400 && out_valid !== 1'b1; n++) @(posedge core_clk);
            check("out_data", b, out_data);
            t1 = cyc;
            g = (b == 8'h86) ? 0 : (b == 8'h79) ? 49 : (b == 8'h80) ? 35 : 751;
        end
        $display("test_ops done");
    endtask
    // Receiver stalls so the third byte finds both entries full
    task automatic test_buffer();
        host_send(8'h11, 1'b0);
        host_send(8'h22, 1'b0);
        host_send(8'h33, 1'b0);
        check("in_ready full", 0, in_ready);
        for (int n = 0; n < 3000 && rx_overrun !== 1'b1; n++) @(posedge core_clk);
        check("rx_overrun", 1, rx_overrun);
        check("rx_data first", 8'h11, rx_data);
        pop();
        check("rx_overrun cleared", 0, rx_overrun);
        check("rx_data second", 8'h22, rx_data);
        pop();
        check("rx_valid empty", 0, rx_valid);
        check("in_ready drained", 1, in_ready);
        $display("test_buffer done");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        test_setup();
        test_ops();
        test_buffer();
        final_report();
    end
    // Longest expected run is near 17000 cycles
    initial begin
        repeat (80000) @(posedge core_clk);
        errors++;
        final_report();
    end
endmodule
